// [akb_key_builder.sv]
// acl half key builder for llc, snap, arp and ipv4 tcp/udp keys
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
module akb_key_builder
    import akb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic frame_valid_i,
    output logic frame_ready_o,
    input wire logic [2:0] frame_class_i,
    input wire logic [47:0] dmac_i,
    input wire logic [47:0] smac_i,
    input wire logic [63:0] l2_payload_i,
    input wire logic [15:0] arp_htype_i,
    input wire logic [15:0] arp_ptype_i,
    input wire logic [7:0] arp_hlen_i,
    input wire logic [7:0] arp_plen_i,
    input wire logic [15:0] arp_oper_i,
    input wire logic [47:0] arp_sha_i,
    input wire logic [47:0] arp_tha_i,
    input wire logic [31:0] arp_spa_i,
    input wire logic [31:0] arp_tpa_i,
    input wire logic [127:0] ip_sip_i,
    input wire logic [127:0] ip_dip_i,
    input wire logic ip_mf_i,
    input wire logic [12:0] ip_frag_ofs_i,
    input wire logic [3:0] ip_ihl_i,
    input wire logic [7:0] ip_ttl_i,
    input wire logic [7:0] ip_tos_i,
    input wire logic [7:0] ip_proto_i,
    input wire logic [15:0] src_port_field_i,
    input wire logic [15:0] dest_port_field_i,
    input wire logic [31:0] tcp_seq_i,
    input wire logic tcp_fin_i,
    input wire logic ptp_i,
    input wire logic [3:0] ptp_msg_type_i,
    input wire logic [11:0] cls_vid_i,
    input wire logic [5:0] cls_dscp_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic key_valid_o,
    output logic [KEY_W-1:0] key_o,
    output logic [KEY_W-1:0] key_mask_o
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    akb_state_e state_reg;
    akb_state_e state_next;
    logic ipv6_standard_key_type_reg;
    logic [15:0] rng_lo_reg [NUM_RNG];
    logic [15:0] rng_hi_reg [NUM_RNG];
    logic [2:0] rng_type_reg [NUM_RNG];
    logic [NUM_RNG-1:0] rng_hit;
    logic [15:0] key_cnt_reg;
    logic [3:0] last_type_reg;
    logic [31:0] rdata_reg;
    logic [KEY_W-1:0] key_reg;
    logic [KEY_W-1:0] mask_reg;
    logic [KEY_W-1:0] kv;
    logic [KEY_W-1:0] km;
    logic [3:0] type_code;
    logic fmt_ok;
    logic accept;
    logic l4_dc;
    logic is_v6;

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic rng_match(input logic [2:0] t, input logic [15:0] lo,
                                       input logic [15:0] hi);
        case (t)
            RNG_SPORT: return in_range(src_port_field_i, lo, hi);
            RNG_DPORT: return in_range(dest_port_field_i, lo, hi);
            RNG_EITHER: return in_range(src_port_field_i, lo, hi) || in_range(dest_port_field_i, lo, hi);
            RNG_VID: return in_range({4'h0, cls_vid_i}, lo, hi);
            RNG_DSCP: return in_range({10'h000, cls_dscp_i}, lo, hi);
            default: return 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // range checkers
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_RNG; g++) begin : g_rng
        assign rng_hit[g] = rng_match(rng_type_reg[g], rng_lo_reg[g], rng_hi_reg[g]);
    end

    // ----------------------------------------------------------------
    // key build
    // ----------------------------------------------------------------
    assign is_v6 = (frame_class_i == CLS_IPV6);
    assign l4_dc = (ip_frag_ofs_i != 13'h0000) || (ip_ihl_i > IHL_MIN);

    // compose value and care mask of the half key
    always_comb begin
        kv = '0;
        km = '0;
        fmt_ok = 1'b0;
        type_code = 4'h0;
        case (frame_class_i)
            CLS_LEN: begin
                fmt_ok = 1'b1;
                kv[DMAC_POS +: 48] = dmac_i;
                kv[SMAC_POS +: 48] = smac_i;
                km[DMAC_POS +: 136] = '1;
                if (l2_payload_i[63:40] == SNAP_LLC) begin
                    type_code = TYPE_SNAP;
                    kv[L2HDR_POS +: L2HDR_W] = l2_payload_i[39:0];
                end else begin
                    type_code = TYPE_LLC;
                    kv[L2HDR_POS +: L2HDR_W] = l2_payload_i[63:24];
                end
            end
            CLS_ARP: begin
                fmt_ok = 1'b1;
                type_code = TYPE_ARP;
                km[ARP_SMAC_POS +: 121] = '1;
                kv[ARP_SMAC_POS +: 48] = smac_i;
                kv[HW_ETH_POS] = (arp_htype_i == HTYPE_ETH);
                kv[PROTO_IP_POS] = (arp_ptype_i == PTYPE_IP);
                kv[LEN_OK_POS] = (arp_hlen_i == HLEN_ETH) && (arp_plen_i == PLEN_IP);
                kv[TGT_EQ_POS] = (arp_tha_i == smac_i);
                kv[SND_EQ_POS] = (arp_sha_i == smac_i);
                // opcodes 1..4 map to 0..3
                if (arp_oper_i >= 16'h0001 && arp_oper_i <= 16'h0004) begin
                    kv[OPC_POS +: 2] = 2'(arp_oper_i - 16'h0001);
                end else begin
                    kv[OP_UNK_POS] = 1'b1;
                end
                kv[ARP_DIP_POS +: 32] = arp_tpa_i;
                kv[ARP_SIP_POS +: 32] = arp_spa_i;
                kv[ARP_EQ_POS] = (arp_tpa_i == arp_spa_i);
            end
            CLS_IPV4, CLS_IPV6: begin
                if ((ip_proto_i == PROTO_TCP || ip_proto_i == PROTO_UDP)
                        && (!is_v6 || !ipv6_standard_key_type_reg)) begin
                    fmt_ok = 1'b1;
                    type_code = TYPE_IP4;
                    km[IP4_POS +: 79] = '1;
                    kv[IP4_POS] = !is_v6;
                    kv[FRAG_POS] = ip_mf_i || (ip_frag_ofs_i != 13'h0000);
                    kv[OFS_POS] = (ip_frag_ofs_i != 13'h0000);
                    kv[OPT_POS] = !is_v6 && (ip_ihl_i > IHL_MIN);
                    kv[TTL_POS] = (ip_ttl_i != 8'h00);
                    kv[TOS_POS +: 8] = ip_tos_i;
                    if (is_v6) begin
                        kv[DIP_POS +: 32] = ip_sip_i[63:32];
                        kv[SIP_POS +: 32] = ip_sip_i[31:0];
                        kv[IPEQ_POS] = (ip_sip_i == ip_dip_i);
                    end else begin
                        kv[DIP_POS +: 32] = ip_dip_i[31:0];
                        kv[SIP_POS +: 32] = ip_sip_i[31:0];
                        kv[IPEQ_POS] = (ip_sip_i[31:0] == ip_dip_i[31:0]);
                    end
                    kv[TCP_POS] = (ip_proto_i == PROTO_TCP);
                    // layer-4 fields only at fragment offset zero and, for ipv4, without options
                    if (!(l4_dc && !is_v6) && !(is_v6 && ip_frag_ofs_i != 13'h0000)) begin
                        km[DPORT_POS +: L4_W] = '1;
                        kv[DPORT_POS +: 16] = dest_port_field_i;
                        kv[SPORT_POS +: 16] = src_port_field_i;
                        kv[PEQ_POS] = (src_port_field_i == dest_port_field_i);
                        kv[RNG_POS +: NUM_RNG] = rng_hit;
                        if (ip_proto_i == PROTO_UDP && ptp_i) begin
                            kv[SEQ_POS] = ptp_msg_type_i[0];
                            kv[FIN_POS] = ptp_msg_type_i[1];
                        end else if (ip_proto_i == PROTO_TCP) begin
                            kv[SEQ_POS] = (tcp_seq_i == 32'h00000000);
                            kv[FIN_POS] = tcp_fin_i;
                        end
                    end
                end
            end
            default: ;
        endcase
        kv[TYPE_POS +: TYPE_W] = type_code;
        km[TYPE_POS +: TYPE_W] = '1;
        km[FIRST_POS] = 1'b1;
    end

    // ----------------------------------------------------------------
    // lookup sequencing
    // ----------------------------------------------------------------
    assign frame_ready_o = (state_reg != ST_FIRST);
    assign accept = frame_valid_i && frame_ready_o && fmt_ok;
    assign key_valid_o = (state_reg != ST_IDLE);
    assign key_o = key_reg;
    assign key_mask_o = mask_reg;

    // next lookup state
    always_comb begin
        case (state_reg)
            ST_FIRST: state_next = ST_SECOND;
            ST_IDLE, ST_SECOND: state_next = accept ? ST_FIRST : ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // key load and first-lookup flag
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_reg <= '0;
            mask_reg <= '0;
        end else if (accept) begin
            key_reg <= kv | (KEY_W'(1) << FIRST_POS);
            mask_reg <= km;
        end else if (state_reg == ST_FIRST) begin
            key_reg[FIRST_POS] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // configuration writes
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ipv6_standard_key_type_reg <= CTRL_RST;
            for (int i = 0; i < NUM_RNG; i++) begin
                rng_lo_reg[i] <= 16'h0000;
                rng_hi_reg[i] <= 16'h0000;
                rng_type_reg[i] <= RNG_OFF;
            end
        end else if (wr_i) begin
            if (addr_i == REG_CTRL) begin
                ipv6_standard_key_type_reg <= wdata_i[0];
            end
            for (int i = 0; i < NUM_RNG; i++) begin
                if (addr_i == REG_RNG_BND + 8'(i * 4)) begin
                    rng_lo_reg[i] <= wdata_i[15:0];
                    rng_hi_reg[i] <= wdata_i[31:16];
                end
                if (addr_i == REG_RNG_CFG + 8'(i * 4)) begin
                    rng_type_reg[i] <= wdata_i[2:0];
                end
            end
        end
    end

    // key statistics
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_cnt_reg <= 16'h0000;
            last_type_reg <= 4'h0;
        end else if (accept) begin
            key_cnt_reg <= key_cnt_reg + 16'h0001;
            last_type_reg <= type_code;
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= 32'h00000000;
            if (rd_i) begin
                if (addr_i == REG_CTRL) begin
                    rdata_reg <= {31'h00000000, ipv6_standard_key_type_reg};
                end else if (addr_i == REG_STATUS) begin
                    rdata_reg <= {key_cnt_reg, 4'h0, last_type_reg, 6'h00, state_reg};
                end
                for (int i = 0; i < NUM_RNG; i++) begin
                    if (addr_i == REG_RNG_BND + 8'(i * 4)) begin
                        rdata_reg <= {rng_hi_reg[i], rng_lo_reg[i]};
                    end
                    if (addr_i == REG_RNG_CFG + 8'(i * 4)) begin
                        rdata_reg <= {29'h00000000, rng_type_reg[i]};
                    end
                end
            end
        end
    end
    assign rdata_o = rdata_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    a_type_code: assert property (accept |=> key_o[3:0] == $past(type_code))
        else $error("key type code wrong");
    a_first_then_clear: assert property (accept |=> key_o[FIRST_POS] ##1
        (key_valid_o && !key_o[FIRST_POS]))
        else $error("lookup order flag wrong");
    a_llc_macs: assert property (accept && frame_class_i == CLS_LEN |=>
        key_o[DMAC_POS +: 48] == $past(dmac_i) && key_o[SMAC_POS +: 48] == $past(smac_i))
        else $error("llc mac fields wrong");
    a_addr_lengths_valid: assert property (accept && frame_class_i == CLS_ARP |=>
        key_o[LEN_OK_POS] == ($past(arp_hlen_i) == HLEN_ETH && $past(arp_plen_i) == PLEN_IP))
        else $error("arp length flag wrong");
    a_arp_ip_equal: assert property (key_valid_o && key_o[3:0] == TYPE_ARP |->
        key_o[ARP_EQ_POS] == (key_o[ARP_DIP_POS +: 32] == key_o[ARP_SIP_POS +: 32]))
        else $error("arp address equality wrong");
    a_l4_dont_care: assert property (accept && frame_class_i == CLS_IPV4 && l4_dc |=>
        key_mask_o[DPORT_POS +: L4_W] == '0)
        else $error("layer-4 fields not masked");
    a_tcp_flag: assert property (accept && type_code == TYPE_IP4 |=>
        key_o[TCP_POS] == ($past(ip_proto_i) == PROTO_TCP))
        else $error("tcp flag wrong");
    a_port_equal: assert property (key_valid_o && key_mask_o[PEQ_POS]
        && key_o[3:0] == TYPE_IP4 |->
        key_o[PEQ_POS] == (key_o[DPORT_POS +: 16] == key_o[SPORT_POS +: 16]))
        else $error("port equality wrong");
    a_ready_hold: assert property (state_reg == ST_FIRST |->
        !frame_ready_o ##1 frame_ready_o)
        else $error("ready timing wrong");
    // field placement of the accepted key
    a_arp_src_mac: assert property (accept && type_code == TYPE_ARP |=>
        key_o[ARP_SMAC_POS +: 48] == $past(smac_i))
        else $error("arp source mac wrong");
    a_arp_hw_space: assert property (accept && type_code == TYPE_ARP |=>
        key_o[HW_ETH_POS] == ($past(arp_htype_i) == HTYPE_ETH))
        else $error("arp space flag wrong");
    a_resolution_opcode: assert property (accept && type_code == TYPE_ARP |=>
        key_o[OP_UNK_POS] == ($past(arp_oper_i) == 16'h0000 || $past(arp_oper_i) > 16'h0004))
        else $error("resolution_opcode flag wrong");
    a_frag_offset: assert property (accept && type_code == TYPE_IP4 |=>
        key_o[OFS_POS] == ($past(ip_frag_ofs_i) != 13'h0000))
        else $error("fragment offset flag wrong");
    a_hop_flag: assert property (accept && type_code == TYPE_IP4 |=>
        key_o[TTL_POS] == ($past(ip_ttl_i) != 8'h00) && key_o[TOS_POS +: 8] == $past(ip_tos_i))
        else $error("ttl or tos field wrong");
    a_ipv4_flag: assert property (accept && type_code == TYPE_IP4 |=>
        key_o[IP4_POS] == ($past(frame_class_i) == CLS_IPV4))
        else $error("ipv4 indicator wrong");

    c_llc_key: cover property (accept && type_code == TYPE_LLC);
    c_snap_key: cover property (accept && type_code == TYPE_SNAP);
    c_arp_key: cover property (accept && type_code == TYPE_ARP);
    c_ip_options: cover property (accept && type_code == TYPE_IP4 && l4_dc);
    c_back_to_back: cover property (accept ##2 accept);
endmodule // akb_key_builder

// [akb_pkg.sv]
// constants for the acl half key builder
package akb_pkg;
    // ----------------------------------------------------------------
    // key geometry
    // ----------------------------------------------------------------
    localparam int KEY_W = 182;
    localparam int TYPE_POS = 0;
    localparam int TYPE_W = 4;
    localparam int FIRST_POS = 4;
    localparam logic [3:0] TYPE_LLC = 4'h1;
    localparam logic [3:0] TYPE_SNAP = 4'h2;
    localparam logic [3:0] TYPE_ARP = 4'h3;
    localparam logic [3:0] TYPE_IP4 = 4'h4;
    // llc / snap
    localparam int DMAC_POS = 46;
    localparam int SMAC_POS = 94;
    localparam int L2HDR_POS = 142;
    localparam int L2HDR_W = 40;
    // arp
    localparam int ARP_SMAC_POS = 46;
    localparam int HW_ETH_POS = 94;
    localparam int PROTO_IP_POS = 95;
    localparam int LEN_OK_POS = 96;
    localparam int TGT_EQ_POS = 97;
    localparam int SND_EQ_POS = 98;
    localparam int OP_UNK_POS = 99;
    localparam int OPC_POS = 100;
    localparam int ARP_DIP_POS = 102;
    localparam int ARP_SIP_POS = 134;
    localparam int ARP_EQ_POS = 166;
    // ipv4 tcp/udp
    localparam int IP4_POS = 46;
    localparam int FRAG_POS = 47;
    localparam int OFS_POS = 48;
    localparam int OPT_POS = 49;
    localparam int TTL_POS = 50;
    localparam int TOS_POS = 51;
    localparam int DIP_POS = 59;
    localparam int SIP_POS = 91;
    localparam int IPEQ_POS = 123;
    localparam int TCP_POS = 124;
    localparam int DPORT_POS = 125;
    localparam int SPORT_POS = 141;
    localparam int RNG_POS = 157;
    localparam int PEQ_POS = 165;
    localparam int SEQ_POS = 166;
    localparam int FIN_POS = 167;
    localparam int L4_W = 43;
    // ----------------------------------------------------------------
    // protocol values
    // ----------------------------------------------------------------
    localparam logic [15:0] HTYPE_ETH = 16'h0001;
    localparam logic [15:0] PTYPE_IP = 16'h0800;
    localparam logic [7:0] HLEN_ETH = 8'h06;
    localparam logic [7:0] PLEN_IP = 8'h04;
    localparam logic [23:0] SNAP_LLC = 24'haaaa03;
    localparam logic [3:0] IHL_MIN = 4'h5;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    // frame class from the parser
    localparam logic [2:0] CLS_LEN = 3'h1;
    localparam logic [2:0] CLS_ARP = 3'h2;
    localparam logic [2:0] CLS_IPV4 = 3'h3;
    localparam logic [2:0] CLS_IPV6 = 3'h4;
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    localparam int NUM_RNG = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RNG_BND = 8'h10;
    localparam logic [7:0] REG_RNG_CFG = 8'h30;
    localparam logic CTRL_RST = 1'b1;
    localparam logic [2:0] RNG_SPORT = 3'h0;
    localparam logic [2:0] RNG_DPORT = 3'h1;
    localparam logic [2:0] RNG_EITHER = 3'h2;
    localparam logic [2:0] RNG_VID = 3'h3;
    localparam logic [2:0] RNG_DSCP = 3'h4;
    localparam logic [2:0] RNG_OFF = 3'h7;
    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} akb_state_e;
endpackage

// [akb_tcam_model.sv]
// one-entry ternary match array standing at the far side of the key builder
`timescale 1ns/10ps
module akb_tcam_model
    import akb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic key_valid_i,
    input wire logic [KEY_W-1:0] key_i,
    input wire logic [KEY_W-1:0] key_mask_i,
    input wire logic [KEY_W-1:0] ent_val_i,
    input wire logic [KEY_W-1:0] ent_care_i,
    output logic hit_o,
    output logic [15:0] lookups_o
);
    // a bit decides only where both the entry and the key care about it
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hit_o <= 1'b0;
            lookups_o <= 16'h0;
        end else if (key_valid_i) begin
            hit_o <= ((key_i ^ ent_val_i) & ent_care_i & key_mask_i) == '0;
            lookups_o <= lookups_o + 16'h1;
        end else begin
            hit_o <= 1'b0; // no lookup, no hit
        end
    end
endmodule // akb_tcam_model

// [tb_top.sv]
// self-checking bench for the acl half key builder
`timescale 1ns/10ps
module tb_top
    import akb_pkg::*;
    ;
    logic mclk_i = 0, rstn_i = 0, frame_valid_i = 0, ip_mf_i = 0, tcp_fin_i = 0, ptp_i = 0;
    logic wr_i = 0, rd_i = 0, frame_ready_o, key_valid_o, hit_o, has, ipv6_standard_key_type = 1;
    logic [2:0] frame_class_i = 0;
    logic [47:0] dmac_i = 0, smac_i = 0, arp_sha_i = 0, arp_tha_i = 0;
    logic [63:0] l2_payload_i = 0;
    logic [15:0] arp_htype_i = 0, arp_ptype_i = 0, arp_oper_i = 0, src_port_field_i = 0;
    logic [15:0] dest_port_field_i = 0, lookups;
    logic [7:0] arp_hlen_i = 0, arp_plen_i = 0, ip_ttl_i = 0, ip_tos_i = 0, ip_proto_i = 0;
    logic [7:0] addr_i = 0;
    logic [31:0] arp_spa_i = 0, arp_tpa_i = 0, tcp_seq_i = 0, wdata_i = 0, rdata_o;
    logic [127:0] ip_sip_i = 0, ip_dip_i = 0;
    logic [12:0] ip_frag_ofs_i = 0;
    logic [3:0] ip_ihl_i = 5, ptp_msg_type_i = 0, lty = 0;
    logic [11:0] cls_vid_i = 0;
    logic [5:0] cls_dscp_i = 0;
    logic [KEY_W-1:0] key_o, key_mask_o, ev, em, dm, ent_val = '0, ent_care = '0;
    logic [15:0] rlo[8], rhi[8];
    logic [2:0] rty[8] = '{RNG_SPORT, RNG_DPORT, RNG_EITHER, RNG_VID, RNG_DSCP, RNG_OFF,
        RNG_SPORT, RNG_DPORT};
    integer seed;
    int n_mismatch = 0, total_checks = 0, nkeys = 0, cyc = 0;

    akb_key_builder DUT (.mclk_i, .rstn_i, .frame_valid_i, .frame_ready_o, .frame_class_i,
        .dmac_i, .smac_i, .l2_payload_i, .arp_htype_i, .arp_ptype_i, .arp_hlen_i,
        .arp_plen_i, .arp_oper_i, .arp_sha_i, .arp_tha_i, .arp_spa_i, .arp_tpa_i, .ip_sip_i,
        .ip_dip_i, .ip_mf_i, .ip_frag_ofs_i, .ip_ihl_i, .ip_ttl_i, .ip_tos_i, .ip_proto_i,
        .src_port_field_i, .dest_port_field_i, .tcp_seq_i, .tcp_fin_i, .ptp_i, .ptp_msg_type_i,
        .cls_vid_i, .cls_dscp_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .key_valid_o,
        .key_o, .key_mask_o);
    akb_tcam_model tcam (.mclk_i, .rstn_i, .key_valid_i(key_valid_o), .key_i(key_o),
        .key_mask_i(key_mask_o), .ent_val_i(ent_val), .ent_care_i(ent_care), .hit_o,
        .lookups_o(lookups));

    // 10 MHz clock and a cycle ceiling against hangs
    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [KEY_W-1:0] seen, input logic [KEY_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle register strobes
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // random value, squeezed to 0 or 1 when equal fields are wanted
    function automatic logic [127:0] rv(input logic n);
        rv = {$random(seed), $random(seed), $random(seed), $random(seed)};
        if (n) rv = rv & 128'h1;
    endfunction

    function automatic logic inr(input int i, input logic [15:0] x);
        return x >= rlo[i] && x <= rhi[i];
    endfunction

    function automatic logic [7:0] rng_hits();
        rng_hits = 8'h0;
        for (int i = 0; i < 8; i++) begin
            case (rty[i])
                RNG_SPORT: rng_hits[i] = inr(i, src_port_field_i);
                RNG_DPORT: rng_hits[i] = inr(i, dest_port_field_i);
                RNG_EITHER: rng_hits[i] = inr(i, src_port_field_i) || inr(i, dest_port_field_i);
                RNG_VID: rng_hits[i] = inr(i, 16'(cls_vid_i));
                RNG_DSCP: rng_hits[i] = inr(i, 16'(cls_dscp_i));
                default: rng_hits[i] = 1'b0;
            endcase
        end
    endfunction

    // expected key value, care mask and the bits whose mask is defined
    task automatic build_exp();
        logic ok, v4, tcp, opk, sq, fn;
        v4 = frame_class_i == CLS_IPV4;
        tcp = ip_proto_i == PROTO_TCP;
        ok = ip_frag_ofs_i == 0 && !(v4 && ip_ihl_i > IHL_MIN);
        opk = arp_oper_i >= 16'h1 && arp_oper_i <= 16'h4;
        sq = tcp ? tcp_seq_i == 0 : ptp_i & ptp_msg_type_i[0];
        fn = tcp ? tcp_fin_i : ptp_i & ptp_msg_type_i[1];
        has = 1'b1;
        ev = 182'h10;
        em = 182'h1f;
        dm = '0;
        if (frame_class_i == CLS_LEN) begin
            dm = '1;
            em[181:46] = '1;
            ev[3:0] = l2_payload_i[63:40] == SNAP_LLC ? TYPE_SNAP : TYPE_LLC;
            ev[181:46] = {l2_payload_i[63:40] == SNAP_LLC ? l2_payload_i[39:0] :
                l2_payload_i[63:24], smac_i, dmac_i};
        end else if (frame_class_i == CLS_ARP) begin
            dm[166:0] = '1;
            em[166:46] = '1;
            ev[3:0] = TYPE_ARP;
            ev[166:46] = {arp_spa_i == arp_tpa_i, arp_spa_i, arp_tpa_i,
                opk ? 2'(arp_oper_i - 16'h1) : 2'h0, !opk, arp_sha_i == smac_i,
                arp_tha_i == smac_i, arp_hlen_i == HLEN_ETH && arp_plen_i == PLEN_IP,
                arp_ptype_i == PTYPE_IP, arp_htype_i == HTYPE_ETH, smac_i};
        end else if ((v4 || (frame_class_i == CLS_IPV6 && !ipv6_standard_key_type)) &&
            (tcp || ip_proto_i == PROTO_UDP)) begin
            dm[167:0] = '1;
            em[124:46] = '1;
            em[167:125] = {43{ok}};
            ev[3:0] = TYPE_IP4;
            ev[167:46] = {ok ? {fn, sq, src_port_field_i == dest_port_field_i, rng_hits(), src_port_field_i,
                dest_port_field_i} : 43'h0, tcp, v4 ? ip_sip_i[31:0] == ip_dip_i[31:0] :
                ip_sip_i == ip_dip_i, ip_sip_i[31:0], v4 ? ip_dip_i[31:0] : ip_sip_i[63:32],
                ip_tos_i, ip_ttl_i != 0, v4 && ip_ihl_i > IHL_MIN, ip_frag_ofs_i != 0,
                ip_mf_i || ip_frag_ofs_i != 0, v4};
        end else begin
            has = 1'b0;
        end
    endtask

    // one random frame, then both lookups and the partner's verdicts
    task automatic send_frame();
        logic [31:0] r;
        logic n;
        logic [KEY_W-1:0] pk;
        r = $random(seed);
        n = r[0];
        pk = key_o;
        @(posedge mclk_i);
        frame_valid_i <= 1'b1;
        frame_class_i <= 3'(rv(0) % 6);
        dmac_i <= 48'(rv(n));
        smac_i <= 48'(rv(n));
        l2_payload_i <= r[7] ? {SNAP_LLC, 40'(rv(0))} : 64'(rv(0));
        arp_htype_i <= 16'(rv(n));
        arp_ptype_i <= r[3] ? PTYPE_IP : 16'(rv(0));
        arp_hlen_i <= r[4] ? HLEN_ETH : 8'(rv(n));
        arp_plen_i <= r[5] ? PLEN_IP : 8'(rv(n));
        arp_oper_i <= 16'(rv(0) % 6);
        {arp_sha_i, arp_tha_i} <= {48'(rv(n)), 48'(rv(n))};
        {arp_spa_i, arp_tpa_i, tcp_seq_i} <= {32'(rv(n)), 32'(rv(n)), 32'(rv(n))};
        {ip_sip_i, ip_dip_i} <= {rv(n), rv(n)};
        {ip_mf_i, tcp_fin_i, ptp_i, ptp_msg_type_i} <= 7'(rv(0));
        ip_frag_ofs_i <= r[8] ? 13'(rv(n)) : 13'h0;
        ip_ihl_i <= 4'h5 + {3'h0, r[9]};
        {ip_ttl_i, ip_tos_i} <= {8'(rv(n)), 8'(rv(0))};
        ip_proto_i <= r[6] ? PROTO_UDP : r[11] ? PROTO_TCP : 8'(rv(0));
        {src_port_field_i, dest_port_field_i} <= {16'(rv(n)), 16'(rv(n))};
        {cls_vid_i, cls_dscp_i} <= {12'(rv(n)), 6'(rv(n))};
        #1;
        build_exp();
        ent_val = ev;
        ent_care = em;
        @(posedge mclk_i);
        frame_valid_i <= 1'b0;
        #1;
        chk(key_valid_o, has);
        chk(frame_ready_o, !has);
        if (has) begin
            nkeys++;
            lty = ev[3:0];
            chk(key_o & em, ev);
            chk(key_mask_o & dm, em);
        end else begin
            chk(key_o, pk);
        end
        @(posedge mclk_i);
        #1;
        chk(key_valid_o, has);
        chk(frame_ready_o, 1'b1);
        if (has) begin
            chk(key_o & em, ev & ~(182'h1 << 4));
            chk(hit_o, 1'b1);
        end
        @(posedge mclk_i);
        #1;
        chk(hit_o, 1'b0);
    endtask

    // reset, register defaults, range setup, then random frames in both ipv6 modes
    initial begin
        seed = 32'h7ce041df;
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        chk(key_o | key_mask_o | key_valid_o, '0);
        rd_reg(REG_CTRL, 32'h1);
        rd_reg(REG_RNG_CFG, 32'h7);
        rd_reg(REG_RNG_BND, 32'h0);
        rd_reg(8'hfc, 32'h0); // unmapped place reads zero
        for (int i = 0; i < 8; i++) begin
            rlo[i] = 16'($random(seed)) & 16'h0003;
            rhi[i] = rlo[i] + (16'($random(seed)) & 16'h7fff);
            wr_reg(8'(REG_RNG_BND + 4 * i), {rhi[i], rlo[i]});
            wr_reg(8'(REG_RNG_CFG + 4 * i), {29'h0, rty[i]});
            rd_reg(8'(REG_RNG_BND + 4 * i), {rhi[i], rlo[i]});
        end
        repeat (300) send_frame();
        wr_reg(REG_CTRL, 32'h0);
        ipv6_standard_key_type = 1'b0;
        rd_reg(REG_CTRL, 32'h0);
        repeat (300) send_frame();
        chk(lookups, 16'(2 * nkeys));
        rd_reg(REG_STATUS, {16'(nkeys), 4'h0, lty, 8'h00});
        conclude();
    end
endmodule // tb_top
